/* hw/sdmc_map.svh */
`ifndef SDMC_MAP_SVH
`define SDMC_MAP_SVH
// ==========================================
// register offsets and reset values
`define SDMC_OFF_CTRL  8'h00
`define SDMC_OFF_MODE  8'h04
`define SDMC_OFF_EXT   8'h08
`define SDMC_OFF_STAT  8'h0c
`define SDMC_CTRL_RST  1'b1
`define SDMC_MODE_RST  10'h000
`define SDMC_EXT_RST   7'h00
// ==========================================
// configuration word fields
`define SDMC_M_BL      2:0
`define SDMC_M_ORDER   3
`define SDMC_M_LAT     6:4
`define SDMC_M_OP      8:7
`define SDMC_M_WSINGLE 9
`define SDMC_E_PARTIAL_REFRESH    2:0
`define SDMC_E_TCR     4:3
// ==========================================
// field codes
`define SDMC_BL1_CODE  3'h0
`define SDMC_BL2_CODE  3'h1
`define SDMC_BL4_CODE  3'h2
`define SDMC_BL8_CODE  3'h3
`define SDMC_BLPG_CODE 3'h7
`define SDMC_CL2_CODE  3'h2
`define SDMC_CL3_CODE  3'h3
`define SDMC_PR_FULL   3'h0
`define SDMC_PR_HALF   3'h1
`define SDMC_PR_QTR    3'h2
`define SDMC_PR_EIGHTH 3'h3
`define SDMC_PR_SIXTN  3'h4
// ==========================================
// command codes {ras_n, cas_n, we_n}
`define SDMC_CMD_LOAD  3'h0
`define SDMC_CMD_READ  3'h5
`define SDMC_CMD_WRITE 3'h4
`define SDMC_CMD_STOP  3'h6
`endif

/* hw/sdmc_pkg.sv */
package sdmc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_BURST = 3'b100
    } sdmc_state_e;
    typedef logic [8:0] sdmc_col_t;
endpackage : sdmc_pkg

/* hw/sdmc_config.sv */
// Operation
// R1: burst lengths 1,2,4,8 both orders; continuous page only sequential.
// R2: interleaved with continuous length is unsupported.
// R3: continuous burst runs until the burst stop command.
// R4: fixed bursts stay and wrap inside an aligned block of burst size.
// R5: upper column bits pick the block, low bits the start offset.
// R6: continuous burst steps columns and wraps inside the open page.
// R7: one configuration bit picks sequential or interleaved order.
// R8: sequential order adds beat count to offset modulo burst length.
// R9: interleaved order is start offset xor beat count.
// R10: read latency is two or three clocks.
// R11: read at edge n drives pins from edge n+m-1.
// R12: controller writes both operating mode bits as zero.
// R13: write single bit makes writes one location, reads keep length.
// R14: load with bank bits 1,0 writes extended register, kept until rewritten.
// R15: controller writes zero into extended bits 7 and above.
// R16: controller loads extended register only when idle, then waits.
// R17: extended settings survive deep power down.
// R18: temperature refresh bits have no effect.
// R19: partial refresh picks the portion kept in self refresh.
// R20: partial refresh never blocks normal reads or writes.
// R21: controller never programs reserved burst length codes.
// R22: burst length from bits 2:0, latency from bits 6:4.
// R23: controller holds both bank bits zero to load main register.
// R24: continuous burst past last column resumes at column zero.
// R25: field codes are design parameters; partial refresh codes are fixed macros here.
// R26: after a fixed burst ends the data pins are released.
`timescale 1ns/1ps
`include "sdmc_map.svh"
module sdmc_config #(
    parameter logic [2:0] BL1_CODE  = `SDMC_BL1_CODE,  // [R25]
    parameter logic [2:0] BL2_CODE  = `SDMC_BL2_CODE,
    parameter logic [2:0] BL4_CODE  = `SDMC_BL4_CODE,
    parameter logic [2:0] BL8_CODE  = `SDMC_BL8_CODE,
    parameter logic [2:0] BLPG_CODE = `SDMC_BLPG_CODE,
    parameter logic [2:0] CL2_CODE  = `SDMC_CL2_CODE,
    parameter logic [2:0] CL3_CODE  = `SDMC_CL3_CODE
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic        bank_sel_hi,
    input  wire logic        bank_sel_lo,
    input  wire logic [12:0] addr,
    output logic [8:0]       col_addr,
    output logic             beat_valid,
    output logic             beat_is_write,
    output logic             dq_oe,
    output logic [3:0]       keep_banks,
    output logic [1:0]       keep_row_top_zero
);
    if (BL1_CODE == BL2_CODE || BL2_CODE == BL4_CODE || BL4_CODE == BL8_CODE ||
        BL8_CODE == BLPG_CODE || CL2_CODE == CL3_CODE) begin : g_chk
        $error("sdmc_config: field codes must be distinct");
    end

    // ==========================================
    // command capture: edge n registers the command
    logic                   cmd_v_r;
    logic [2:0]             cmd_r;
    logic [1:0]             ba_r;
    logic [12:0]            addr_r;
    logic                   ctrl_en_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_v_r <= 1'b0;
            cmd_r   <= 3'h7;
            ba_r    <= 2'h0;
            addr_r  <= 13'h0000;
        end else begin
            cmd_v_r <= ~cs_n & ctrl_en_r;
            cmd_r   <= {ras_n, cas_n, we_n};
            ba_r    <= {bank_sel_hi, bank_sel_lo};
            addr_r  <= addr;
        end
    end

    // ==========================================
    // configuration registers and burst engine
    logic [9:0]             mode_r,  mode_nxt;
    logic [6:0]             ext_r,   ext_nxt;
    sdmc_pkg::sdmc_state_e  st_r,    st_nxt;
    sdmc_pkg::sdmc_col_t    start_r, start_nxt;
    logic [8:0]             beat_r,  beat_nxt;
    logic [8:0]             mask_r,  mask_nxt;
    logic                   il_r,    il_nxt;
    logic                   pg_r,    pg_nxt;
    logic                   wr_r,    wr_nxt;
    sdmc_pkg::sdmc_col_t    col_r,   col_nxt;
    logic                   bv_r,    bv_nxt;
    logic                   bw_r,    bw_nxt;
    logic                   oe_r,    oe_nxt;
    logic [3:0]             kb_r,    kb_nxt;
    logic [1:0]             kr_r,    kr_nxt;
    logic                   start_rd, start_wr, stop_cmd, cmd_hit, load_cmd;
    logic                   cl3_w, cfg_err;
    logic [8:0]             cfg_mask;
    logic                   cfg_pg;
    logic                   emit;
    logic [8:0]             idx;

    assign load_cmd = cmd_v_r && cmd_r == `SDMC_CMD_LOAD;
    assign start_rd = cmd_v_r && cmd_r == `SDMC_CMD_READ;  // [R20]
    assign start_wr = cmd_v_r && cmd_r == `SDMC_CMD_WRITE;
    assign stop_cmd = cmd_v_r && cmd_r == `SDMC_CMD_STOP;
    assign cmd_hit  = start_rd | start_wr | stop_cmd;
    assign cl3_w    = mode_r[`SDMC_M_LAT] != CL2_CODE;  // [R10] [R22]

    function automatic sdmc_pkg::sdmc_col_t beat_col(input logic [8:0] s, input logic [8:0] i,
                                                     input logic [8:0] m, input logic il, input logic pg);
        if (pg)
            beat_col = 9'(s + i);  // [R6] [R24]
        else if (il)
            beat_col = s ^ (i & m);  // [R9]
        else
            beat_col = (s & ~m) | (9'(s + i) & m);  // [R4] [R5] [R8]
    endfunction : beat_col

    // reserved length codes fall back to single beats, flagged in status
    always_comb begin
        cfg_mask = 9'h000;
        cfg_pg   = 1'b0;
        cfg_err  = 1'b0;
        case (mode_r[`SDMC_M_BL])  // [R1] [R22]
            BL1_CODE: cfg_mask = 9'h000;
            BL2_CODE: cfg_mask = 9'h001;
            BL4_CODE: cfg_mask = 9'h003;
            BL8_CODE: cfg_mask = 9'h007;
            BLPG_CODE: begin
                cfg_pg  = ~mode_r[`SDMC_M_ORDER];  // [R2]
                cfg_err = mode_r[`SDMC_M_ORDER];
            end
            default: cfg_err = 1'b1;
        endcase
        if (mode_r[`SDMC_M_LAT] != CL2_CODE && mode_r[`SDMC_M_LAT] != CL3_CODE)
            cfg_err = 1'b1;
    end

    always_comb begin
        mode_nxt  = mode_r;
        ext_nxt   = ext_r;
        st_nxt    = st_r;
        start_nxt = start_r;
        mask_nxt  = mask_r;
        il_nxt    = il_r;
        pg_nxt    = pg_r;
        wr_nxt    = wr_r;
        beat_nxt  = beat_r;
        col_nxt   = col_r;
        bv_nxt    = 1'b0;
        bw_nxt    = 1'b0;
        oe_nxt    = 1'b0;  // [R26]
        emit      = 1'b0;
        idx       = beat_r;
        if (load_cmd && ba_r == 2'b00)
            mode_nxt = addr_r[9:0];
        else if (load_cmd && ba_r == 2'b10)
            ext_nxt = addr_r[6:0];  // [R14] [R17]
        unique case (st_r)
            sdmc_pkg::ST_IDLE: emit = 1'b0;
            sdmc_pkg::ST_WAIT: begin
                emit = 1'b1;
                idx  = 9'h000;
            end
            sdmc_pkg::ST_BURST: emit = 1'b1;
        endcase
        if (start_rd || start_wr) begin
            start_nxt = addr_r[8:0];
            wr_nxt    = start_wr;
            il_nxt    = mode_r[`SDMC_M_ORDER];  // [R7]
            if (start_wr && mode_r[`SDMC_M_WSINGLE]) begin
                mask_nxt = 9'h000;  // [R13]
                pg_nxt   = 1'b0;
            end else begin
                mask_nxt = cfg_mask;
                pg_nxt   = cfg_pg;
            end
            idx = 9'h000;
            if (start_rd && cl3_w) begin
                emit   = 1'b0;
                st_nxt = sdmc_pkg::ST_WAIT;  // [R10]
            end else begin
                emit = 1'b1;
            end
        end else if (stop_cmd) begin
            emit   = 1'b0;
            st_nxt = sdmc_pkg::ST_IDLE;  // [R3]
        end
        if (emit) begin
            col_nxt  = beat_col(start_nxt, idx, mask_nxt, il_nxt, pg_nxt);
            bv_nxt   = 1'b1;
            bw_nxt   = wr_nxt;
            oe_nxt   = ~wr_nxt;  // [R11]
            beat_nxt = 9'(idx + 9'h001);
            if (!pg_nxt && idx == mask_nxt)
                st_nxt = sdmc_pkg::ST_IDLE;  // [R4]
            else
                st_nxt = sdmc_pkg::ST_BURST;
        end
        // temperature refresh field is stored for readback only
        kb_nxt = 4'hf;  // [R18] [R19]
        kr_nxt = 2'b00;
        unique case (ext_r[`SDMC_E_PARTIAL_REFRESH])
            `SDMC_PR_HALF:   kb_nxt = 4'h3;
            `SDMC_PR_QTR:    kb_nxt = 4'h1;
            `SDMC_PR_EIGHTH: begin
                kb_nxt = 4'h1;
                kr_nxt = 2'b10;
            end
            `SDMC_PR_SIXTN: begin
                kb_nxt = 4'h1;
                kr_nxt = 2'b11;
            end
            default: kb_nxt = 4'hf;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r  <= `SDMC_MODE_RST;
            ext_r   <= `SDMC_EXT_RST;
            st_r    <= sdmc_pkg::ST_IDLE;
            start_r <= 9'h000;
            mask_r  <= 9'h000;
            il_r    <= 1'b0;
            pg_r    <= 1'b0;
            wr_r    <= 1'b0;
            beat_r  <= 9'h000;
            col_r   <= 9'h000;
            bv_r    <= 1'b0;
            bw_r    <= 1'b0;
            oe_r    <= 1'b0;
            kb_r    <= 4'hf;
            kr_r    <= 2'b00;
        end else begin
            mode_r  <= mode_nxt;
            ext_r   <= ext_nxt;
            st_r    <= st_nxt;
            start_r <= start_nxt;
            mask_r  <= mask_nxt;
            il_r    <= il_nxt;
            pg_r    <= pg_nxt;
            wr_r    <= wr_nxt;
            beat_r  <= beat_nxt;
            col_r   <= col_nxt;
            bv_r    <= bv_nxt;
            bw_r    <= bw_nxt;
            oe_r    <= oe_nxt;
            kb_r    <= kb_nxt;
            kr_r    <= kr_nxt;
        end
    end

    assign col_addr          = col_r;
    assign beat_valid        = bv_r;
    assign beat_is_write     = bw_r;
    assign dq_oe             = oe_r;
    assign keep_banks        = kb_r;
    assign keep_row_top_zero = kr_r;

    // ==========================================
    // axi4-lite slave, one write and one read in flight
    logic                   awr_r, awr_nxt, wr_rdy_r, wr_rdy_nxt, arr_r, arr_nxt;
    logic                   awh_r, awh_nxt, wh_r, wh_nxt;
    logic [7:0]             awa_r, awa_nxt;
    logic [31:0]            wd_r, wd_nxt;
    logic                   ws0_r, ws0_nxt;
    logic                   bv2_r, bv2_nxt, rv_r, rv_nxt;
    logic [1:0]             br_r, br_nxt, rr_r, rr_nxt;
    logic [31:0]            rd_r, rd_nxt;
    logic                   ctrl_en_nxt;

    always_comb begin
        awh_nxt     = awh_r | (s_axi_awvalid & awr_r);
        wh_nxt      = wh_r | (s_axi_wvalid & wr_rdy_r);
        awa_nxt     = (s_axi_awvalid & awr_r) ? s_axi_awaddr : awa_r;
        wd_nxt      = (s_axi_wvalid & wr_rdy_r) ? s_axi_wdata : wd_r;
        ws0_nxt     = (s_axi_wvalid & wr_rdy_r) ? s_axi_wstrb[0] : ws0_r;
        bv2_nxt     = bv2_r & ~s_axi_bready;
        br_nxt      = br_r;
        ctrl_en_nxt = ctrl_en_r;
        if (awh_r && wh_r && !bv2_r) begin
            awh_nxt = 1'b0;
            wh_nxt  = 1'b0;
            bv2_nxt = 1'b1;
            br_nxt  = 2'b00;
            if (awa_r == `SDMC_OFF_CTRL) begin
                if (ws0_r)
                    ctrl_en_nxt = wd_r[0];
            end else if (awa_r != `SDMC_OFF_MODE && awa_r != `SDMC_OFF_EXT && awa_r != `SDMC_OFF_STAT)
                br_nxt = 2'b11;
        end
        awr_nxt = ~awh_nxt & ~bv2_nxt;
        wr_rdy_nxt = ~wh_nxt & ~bv2_nxt;
        rv_nxt  = rv_r & ~s_axi_rready;
        rd_r_hold: begin
            rd_nxt = rd_r;
            rr_nxt = rr_r;
        end
        if (s_axi_arvalid && arr_r) begin
            rv_nxt = 1'b1;
            rr_nxt = 2'b00;
            unique case (s_axi_araddr)
                `SDMC_OFF_CTRL: rd_nxt = {31'h0, ctrl_en_r};
                `SDMC_OFF_MODE: rd_nxt = {22'h0, mode_r};
                `SDMC_OFF_EXT:  rd_nxt = {25'h0, ext_r};
                `SDMC_OFF_STAT: rd_nxt = {20'h0, cfg_err, oe_r, st_r != sdmc_pkg::ST_IDLE, beat_r};
                default: begin
                    rd_nxt = 32'h0;
                    rr_nxt = 2'b11;
                end
            endcase
        end
        arr_nxt = ~rv_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awr_r     <= 1'b1;
            wr_rdy_r  <= 1'b1;
            arr_r     <= 1'b1;
            awh_r     <= 1'b0;
            wh_r      <= 1'b0;
            awa_r     <= 8'h00;
            wd_r      <= 32'h0;
            ws0_r     <= 1'b0;
            bv2_r     <= 1'b0;
            br_r      <= 2'b00;
            rv_r      <= 1'b0;
            rr_r      <= 2'b00;
            rd_r      <= 32'h0;
            ctrl_en_r <= `SDMC_CTRL_RST;
        end else begin
            awr_r     <= awr_nxt;
            wr_rdy_r  <= wr_rdy_nxt;
            arr_r     <= arr_nxt;
            awh_r     <= awh_nxt;
            wh_r      <= wh_nxt;
            awa_r     <= awa_nxt;
            wd_r      <= wd_nxt;
            ws0_r     <= ws0_nxt;
            bv2_r     <= bv2_nxt;
            br_r      <= br_nxt;
            rv_r      <= rv_nxt;
            rr_r      <= rr_nxt;
            rd_r      <= rd_nxt;
            ctrl_en_r <= ctrl_en_nxt;
        end
    end

    assign s_axi_awready = awr_r;
    assign s_axi_wready  = wr_rdy_r;
    assign s_axi_bvalid  = bv2_r;
    assign s_axi_bresp   = br_r;
    assign s_axi_arready = arr_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rresp   = rr_r;
    assign s_axi_rdata   = rd_r;

    // ==========================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_OE_CL2: assert property (start_rd && !cl3_w |=> dq_oe && beat_valid) // [R11]
        else $error("read data not driven one cycle after latency-2 read");
    AST_OE_CL3: assert property (start_rd && cl3_w ##1 !cmd_hit |-> !dq_oe ##1 dq_oe) // [R10]
        else $error("latency-3 read drove pins at wrong edge");
    AST_SEQ_STEP: assert property (st_r == sdmc_pkg::ST_BURST && !il_r && !pg_r && !cmd_hit
        |=> (col_r & mask_r) == (9'($past(col_r) + 9'h001) & mask_r)) // [R8]
        else $error("sequential beat did not step by one in block");
    AST_BLOCK_FIX: assert property (beat_valid && !pg_r |-> (col_r & ~mask_r) == (start_r & ~mask_r)) // [R5]
        else $error("burst left its aligned block");
    AST_IL_XOR: assert property (beat_valid && il_r |-> col_r == (start_r ^ (9'(beat_r - 9'h001) & mask_r))) // [R9]
        else $error("interleaved beat is not start xor count");
    AST_PAGE_WRAP: assert property (st_r == sdmc_pkg::ST_BURST && pg_r && !cmd_hit
        |=> beat_valid && col_addr == 9'($past(col_r) + 9'h001)) // [R24]
        else $error("page burst did not step or wrap");
    AST_FIXED_END: assert property (beat_valid && !pg_r && 9'(beat_r - 9'h001) == mask_r && !cmd_hit
        |=> !dq_oe && !beat_valid) // [R26]
        else $error("pins still driven after last beat");
    AST_WR_SINGLE: assert property (start_wr && mode_r[`SDMC_M_WSINGLE] ##1 !cmd_hit
        |-> beat_is_write ##1 !beat_valid) // [R13]
        else $error("write burst longer than one in single-write mode");
    AST_EXT_LOAD: assert property (load_cmd && ba_r == 2'b10 |=> ext_r == $past(addr_r[6:0])) // [R14]
        else $error("extended register not loaded");
    AST_STOP: assert property (stop_cmd |=> !beat_valid && !dq_oe) // [R3]
        else $error("burst continued after stop");
    AST_NO_IL_PAGE: assert property (beat_valid |-> !(il_r && pg_r)) // [R2]
        else $error("interleaved continuous burst ran");

    COV_CL3_READ: cover property (start_rd && cl3_w ##2 dq_oe);
    COV_PAGE_STOP: cover property (beat_valid && pg_r ##1 stop_cmd);
    COV_IL8: cover property (beat_valid && il_r && mask_r == 9'h007 && beat_r == 9'h008);
endmodule : sdmc_config

/* tb/sdmc_ctrl_model.sv */
`timescale 1ns/1ps
`include "sdmc_map.svh"
module sdmc_ctrl_model (
    input  wire logic        aclk,
    input  wire logic        req,
    input  wire logic [2:0]  op,
    input  wire logic        ext,
    input  wire logic [12:0] arg,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic             bank_sel_hi,
    output logic             bank_sel_lo,
    output logic [12:0]      addr
);
    logic [12:0] last_r = 13'h0000;
    logic [12:0] last_nxt;
    logic        ld;
    // ==========================================
    // command pins, released address lines show a changing pattern
    always_comb begin
        ld = (op == `SDMC_CMD_LOAD);
        last_nxt = arg;
        if (ld && ext)
            last_nxt = {6'h00, arg[6:0]};
        else if (ld)
            last_nxt = {3'h0, arg[9], 2'b00, arg[6:0]};
        cs_n = ~req;
        {ras_n, cas_n, we_n} = req ? op : 3'h7;
        bank_sel_hi = req ? (ld & ext) : 1'b1;
        bank_sel_lo = ~req;
        addr = req ? last_nxt : ~last_r;
    end
    always_ff @(posedge aclk) begin
        if (req)
            last_r <= last_nxt;
    end
endmodule : sdmc_ctrl_model

/* tb/tb_sdmc_config.sv */
`timescale 1ns/1ps
`include "sdmc_map.svh"
module tb_sdmc_config;
    typedef struct packed {logic [8:0] col; logic wr; logic [31:0] at;} sdmc_note_s;
    logic        aclk = 1'b0, aresetn = 1'b0, req = 1'b0, ext = 1'b0, trunc = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, rng = 32'h20, t;
    logic [3:0]  s_axi_wstrb = 4'h0, keep_banks;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ws;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs, keep_row_top_zero;
    logic        cs_n, ras_n, cas_n, we_n, bank_sel_hi, bank_sel_lo, beat_valid, beat_is_write, dq_oe;
    logic [2:0]  op = 3'h7;
    logic [12:0] arg = 13'h0, addr;
    logic [8:0]  col_addr;
    logic [2:0]  blc [4] = '{`SDMC_BL1_CODE, `SDMC_BL2_CODE, `SDMC_BL4_CODE, `SDMC_BL8_CODE};
    logic [3:0]  kb [5] = '{4'hf, 4'h3, 4'h1, 4'h1, 4'h1};
    logic [1:0]  kr [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h3};
    int          miscompares = 0, total_checks = 0, cyc = 0, k, len, il, lat;
    sdmc_note_s  q [$];
    sdmc_note_s  n;
    // ==========================================
    // clock, design and partner
    always #10 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    sdmc_config dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel_hi, .bank_sel_lo, .addr, .col_addr,
        .beat_valid, .beat_is_write, .dq_oe, .keep_banks, .keep_row_top_zero);
    sdmc_ctrl_model ctl_u (.aclk, .req, .op, .ext, .arg, .cs_n, .ras_n, .cas_n, .we_n,
        .bank_sel_hi, .bank_sel_lo, .addr);
    // ==========================================
    // helpers
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    function automatic logic [8:0] colx(input logic [8:0] s, input int i, input int ln, input int lv, input int pg);
        logic [8:0] m;
        m = 9'(ln - 1);
        if (pg != 0)
            return s + 9'(i);
        return (s & ~m) | ((lv != 0) ? ((s & m) ^ 9'(i)) : (((s & m) + 9'(i)) & m));
    endfunction : colx
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t %s seen %h exp %h", $time, m, s, e);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic b;
        b = 1'b0;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin b = 1'b1; bs = s_axi_bresp; s_axi_bready <= 1'b0; end
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin b = 1'b1; rd = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 1'b0; end
        end
    endtask : axi_rd
    // notes each expected beat, then drives one command for one edge
    task automatic cmd(input logic [2:0] o, input logic e, input logic [12:0] a, input int lt, ln, lv, pg);
        for (int i = 0; i < ln; i++)
            q.push_back(sdmc_note_s'{colx(a[8:0], i, ln, lv, pg), o == `SDMC_CMD_WRITE, cyc + lt + 1 + i});
        req <= 1'b1; op <= o; ext <= e; arg <= a;
        @(posedge aclk);
        req <= 1'b0; op <= 3'h7;
        if (o == `SDMC_CMD_LOAD) repeat (3) @(posedge aclk);
    endtask : cmd
    task automatic drain();
        while (q.size() != 0) @(posedge aclk);
        repeat (2) @(posedge aclk);
        chk(dq_oe, 0, "pins kept driven");
        chk(beat_valid, 0, "burst overran");
    endtask : drain
    // ==========================================
    // beat monitor and timeout
    always @(posedge aclk) begin
        if (aresetn && beat_valid === 1'b1) begin
            if (q.size() == 0) chk(1, 0, "unexpected beat");
            else begin
                n = q.pop_front();
                chk(col_addr, n.col, "column");
                chk(beat_is_write, n.wr, "direction");
                chk(dq_oe, !n.wr, "pin drive");
                if (!trunc) chk(cyc, n.at, "beat time");
            end
        end
        if (!trunc && q.size() != 0 && q[0].at < cyc) begin chk(0, 1, "missing beat"); q.pop_front(); end
        if (cyc > 6000) begin chk(0, 1, "timeout"); test_done(); end
    end
    // ==========================================
    // scenarios
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_wr(`SDMC_OFF_MODE, 32'h3ff);
        chk(bs, 0, "ignored write resp");
        axi_rd(`SDMC_OFF_CTRL);
        chk(rd, 1, "ctrl reset");
        axi_rd(`SDMC_OFF_MODE);
        chk(rd, 0, "mode read only");
        axi_rd(8'h10);
        chk(rs, 2'b11, "unmapped resp");
        $display("test registers done");
        for (k = 0; k < 5; k++) begin
            t = xs();
            cmd(`SDMC_CMD_LOAD, 1'b1, {t[12:3], 3'(k)}, 0, 0, 0, 0);
            chk(keep_banks, kb[k], "kept banks");
            chk(keep_row_top_zero, kr[k], "kept rows");
            axi_rd(`SDMC_OFF_EXT);
            chk(rd, {25'h0, t[6:3], 3'(k)}, "ext value");
        end
        $display("test partial refresh done");
        for (k = 0; k < 16; k++) begin
            len = 1 << (k % 4); il = (k / 4) % 2; lat = 2 + k / 8; ws = (k % 3 == 0);
            cmd(`SDMC_CMD_LOAD, 1'b0, {3'h0, ws, 2'b00, (lat == 2) ? `SDMC_CL2_CODE : `SDMC_CL3_CODE,
                1'(il), blc[k % 4]}, 0, 0, 0, 0);
            t = xs();
            cmd(`SDMC_CMD_READ, 1'b0, t[12:0], lat, len, il, 0);
            drain();
            t = xs();
            cmd(`SDMC_CMD_WRITE, 1'b0, t[12:0], 2, ws ? 1 : len, il, 0);
            drain();
        end
        $display("test burst orders done");
        cmd(`SDMC_CMD_LOAD, 1'b0, {6'h0, `SDMC_CL2_CODE, 1'b0, `SDMC_BLPG_CODE}, 0, 0, 0, 0);
        cmd(`SDMC_CMD_READ, 1'b0, 13'h1fe, 2, 8, 0, 1);
        repeat (3) @(posedge aclk);
        trunc = 1'b1;
        cmd(`SDMC_CMD_STOP, 1'b0, 13'h0, 0, 0, 0, 0);
        repeat (4) @(posedge aclk);
        chk(beat_valid, 0, "stop ignored");
        chk((8 - q.size()) inside {[3:4]}, 1, "beats before stop");
        q.delete();
        trunc = 1'b0;
        $display("test page burst done");
        cmd(`SDMC_CMD_LOAD, 1'b0, {6'h0, `SDMC_CL2_CODE, 1'b1, `SDMC_BLPG_CODE}, 0, 0, 0, 0);
        cmd(`SDMC_CMD_READ, 1'b0, 13'h005, 2, 1, 0, 0);
        drain();
        axi_rd(`SDMC_OFF_STAT);
        chk(rd[11], 1, "unsupported flag");
        $display("test unsupported mode done");
        axi_wr(`SDMC_OFF_CTRL, 32'h0);
        cmd(`SDMC_CMD_READ, 1'b0, 13'h0, 2, 0, 0, 0);
        repeat (6) @(posedge aclk);
        axi_wr(`SDMC_OFF_CTRL, 32'h1);
        cmd(`SDMC_CMD_READ, 1'b0, 13'h003, 2, 1, 0, 0);
        drain();
        $display("test disabled link done");
        test_done();
    end
endmodule : tb_sdmc_config
